// >>> rtl/gpio_def_pkg.sv
// Constants and carrier types for the D/E/F general-purpose port block.
// Assumes an 8-bit register port on the system clock.
package gpio_def_pkg;

   // ----------------------------------------------------------------
   // Register map (word index on the plain register port)
   // ----------------------------------------------------------------
   localparam logic [3:0] ADDR_PIN_D      = 4'h0;
   localparam logic [3:0] ADDR_LAT_D      = 4'h1;
   localparam logic [3:0] ADDR_DIR_D      = 4'h2;
   localparam logic [3:0] ADDR_PIN_E      = 4'h3;
   localparam logic [3:0] ADDR_LAT_E      = 4'h4;
   localparam logic [3:0] ADDR_DIR_E      = 4'h5;
   localparam logic [3:0] ADDR_PIN_F      = 4'h6;
   localparam logic [3:0] ADDR_LAT_F      = 4'h7;
   localparam logic [3:0] ADDR_DIR_F      = 4'h8;
   localparam logic [3:0] ADDR_SP_CTRL    = 4'h9;
   localparam logic [3:0] ADDR_IRQ_STAT   = 4'hA;
   localparam logic [3:0] ADDR_IRQ_MASK   = 4'hB;
   localparam logic [3:0] ADDR_ANALOG_F   = 4'hC;

   // ----------------------------------------------------------------
   // Fields and reset values
   // ----------------------------------------------------------------
   localparam int         BIT_IN_FULL     = 7;
   localparam int         BIT_OUT_FULL    = 6;
   localparam int         BIT_IN_OVF      = 5;
   localparam int         BIT_SP_EN       = 4;
   localparam int         PIN_RD_STB      = 0;
   localparam int         PIN_WR_STB      = 1;
   localparam int         PIN_CSEL        = 2;
   localparam int         PIN_CAPCMP      = 7;
   localparam logic [7:0] SP_CTRL_MASK    = 8'hF0;
   localparam logic [7:0] DIR_RESET       = 8'hFF;
   localparam logic [7:0] CTRL_RESET      = 8'h00;
   localparam logic [7:0] LAT_RESET       = 8'h00;
   localparam logic [7:0] ANALOG_F_RESET  = 8'h7F;
   localparam logic [7:0] STROBES_E       = 8'h07;

   // Interrupt status bits: slave port events
   localparam int         IRQ_IN_FULL     = 0;
   localparam int         IRQ_OUT_EMPTY   = 1;
   localparam int         IRQ_IN_OVF      = 2;
   localparam logic [7:0] IRQ_IMPL        = 8'h07;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } reg_req_s;

   typedef struct packed {
      logic [7:0] pin_out;
      logic [7:0] pin_oe;
   } pin_drv_s;

endpackage : gpio_def_pkg

// >>> rtl/gpio_ports_def.sv
// Ports D, E and F: direction, output latch and pin read paths, with
// the slave port takeover of D and E[2:0] and capture/compare on E7.
// Assumes pins are synchronous to sys_clk; slave port data logic and
// the analog blocks sit outside and talk over plain ports.
//
// Behaviour
// - A direction bit of one turns the pin driver off so the pin is input.
// - A direction bit of zero drives the pin from its output latch.
// - The output latch register reads and writes the latch, not the pin.
// - The port register reads pin levels and writes the output latch.
// - The latch register reads the latch, and both write the same latch.
// - All direction registers reset to all ones.
// - Port and latch contents are undefined at power-on and kept otherwise; here every rst_b reset clears the latches to zero.
// - In slave port mode port D carries the slave port data byte.
// - In slave port mode pin E0 is the slave port read strobe input.
// - In slave port mode pin E1 is the slave port write strobe input.
// - In slave port mode pin E2 is the slave port chip select input.
// - Pin E7 is shared with the second capture/compare unit.
// - The slave port control holds three flags and the mode bit in bits 7..4, low bits zero.
// - After reset port F pins 6..0 are inputs and read as zero.
// - Setting the enable bit turns port D into an 8-bit slave port.
`timescale 1ns/1ps

module gpio_ports_def
   import gpio_def_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire logic       rst_b,
   input  wire reg_req_s   bus_req,
   output logic      [7:0] bus_rdata,
   input  wire logic [7:0] pin_in_d,
   output pin_drv_s        pin_drv_d,
   input  wire logic [7:0] pin_in_e,
   output pin_drv_s        pin_drv_e,
   input  wire logic [7:0] pin_in_f,
   output pin_drv_s        pin_drv_f,
   input  wire logic [7:0] sp_data_out,
   output logic      [7:0] sp_data_in,
   output logic            sp_rd_strobe,
   output logic            sp_wr_strobe,
   output logic            sp_chip_sel,
   input  wire logic       sp_in_full_set,
   input  wire logic       sp_out_full_set,
   input  wire logic       sp_out_full_clr,
   input  wire logic       sp_in_ovf_set,
   input  wire logic       sp_in_full_clr,
   input  wire logic       capcmp_en,
   input  wire logic       capcmp_drive,
   input  wire logic       capcmp_out,
   output logic            capcmp_in,
   input  wire logic [7:0] analog_f_sel,
   output logic            irq
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] lat_d;
      logic [7:0] lat_e;
      logic [7:0] lat_f;
      logic [7:0] dir_d;
      logic [7:0] dir_e;
      logic [7:0] dir_f;
      logic [7:0] sp_ctrl;
      logic [7:0] irq_stat;
      logic [7:0] irq_mask;
      logic [7:0] rdata;
   } state_s;

   state_s state_reg;
   state_s state_next;

   logic       sp_mode;
   logic [7:0] pin_f_read;
   logic [7:0] oe_d;
   logic [7:0] oe_e;
   logic [7:0] oe_f;

   // Pin driver enable from a direction byte and an override pair
   function automatic logic [7:0] drive_en(input logic [7:0] dir,
                                           input logic [7:0] ovr_mask,
                                           input logic [7:0] ovr_oe);
      drive_en = (~dir & ~ovr_mask) | (ovr_mask & ovr_oe);
   endfunction : drive_en

   // Register index decode, used by both strobes
   function automatic logic hit(input reg_req_s r,
                                input logic [3:0] a);
      hit = (r.addr == a);
   endfunction : hit

   // ----------------------------------------------------------------
   // Pin muxing
   // ----------------------------------------------------------------
   assign sp_mode = state_reg.sp_ctrl[BIT_SP_EN];

   // Override gates only the enable; dir registers stay untouched
   always_comb
   begin
      oe_d = drive_en(state_reg.dir_d, 8'h00, 8'h00);
      if (sp_mode)
      begin
         // Bus drives only while reading with chip select low
         oe_d = (!pin_in_e[PIN_RD_STB] && !pin_in_e[PIN_CSEL]) ?
                8'hFF : 8'h00;
      end
      oe_e = drive_en(state_reg.dir_e,
                      {capcmp_en, 4'h0, {3{sp_mode}}},
                      {capcmp_drive, 7'h00});
   end

   assign oe_f = drive_en(state_reg.dir_f, 8'h00, 8'h00);

   generate
      for (genvar i = 0; i < 8; i++)
      begin : g_pins
         // Analog-selected pins read as zero in the digital path
         assign pin_f_read[i] = analog_f_sel[i] ? 1'b0 : pin_in_f[i];
      end
   endgenerate

   always_comb
   begin
      pin_drv_d.pin_oe  = oe_d;
      pin_drv_d.pin_out = sp_mode ? sp_data_out : state_reg.lat_d;
      pin_drv_e.pin_oe  = oe_e;
      pin_drv_e.pin_out = state_reg.lat_e;
      if (capcmp_en)
      begin
         pin_drv_e.pin_out[PIN_CAPCMP] = capcmp_out;
      end
      pin_drv_f.pin_oe  = oe_f;
      pin_drv_f.pin_out = state_reg.lat_f;
   end

   assign sp_data_in   = pin_in_d;
   assign sp_rd_strobe = sp_mode & ~pin_in_e[PIN_RD_STB];
   assign sp_wr_strobe = sp_mode & ~pin_in_e[PIN_WR_STB];
   assign sp_chip_sel  = sp_mode & ~pin_in_e[PIN_CSEL];
   assign capcmp_in    = pin_in_e[PIN_CAPCMP];
   assign irq          = |(state_reg.irq_stat & state_reg.irq_mask);
   assign bus_rdata    = state_reg.rdata;

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb
   begin
      logic [7:0] ev;
      ev = 8'h00;
      state_next = state_reg;
      state_next.rdata = 8'h00;
      ev[IRQ_IN_FULL]   = sp_in_full_set;
      ev[IRQ_OUT_EMPTY] = sp_out_full_clr;
      ev[IRQ_IN_OVF]    = sp_in_ovf_set;

      if (bus_req.wr)
      begin
         case (bus_req.addr)
            ADDR_PIN_D, ADDR_LAT_D: state_next.lat_d = bus_req.wdata;
            ADDR_PIN_E, ADDR_LAT_E: state_next.lat_e = bus_req.wdata;
            ADDR_PIN_F, ADDR_LAT_F: state_next.lat_f = bus_req.wdata;
            ADDR_DIR_D:    state_next.dir_d = bus_req.wdata;
            ADDR_DIR_E:    state_next.dir_e = bus_req.wdata;
            ADDR_DIR_F:    state_next.dir_f = bus_req.wdata;
            ADDR_SP_CTRL:
            begin
               // Software writes the mode bit and can only clear the overflow bit
               state_next.sp_ctrl[BIT_SP_EN] = bus_req.wdata[BIT_SP_EN];
               state_next.sp_ctrl[BIT_IN_OVF] =
                  state_reg.sp_ctrl[BIT_IN_OVF] & bus_req.wdata[BIT_IN_OVF];
            end
            ADDR_IRQ_STAT:
               state_next.irq_stat = state_reg.irq_stat & ~bus_req.wdata;
            ADDR_IRQ_MASK: state_next.irq_mask = bus_req.wdata & IRQ_IMPL;
            default: ;
         endcase
      end

      // Hardware set wins over a software clear in the same cycle
      state_next.irq_stat = state_next.irq_stat | ev;
      if (sp_in_full_clr)
         state_next.sp_ctrl[BIT_IN_FULL] = 1'b0;
      if (sp_in_full_set)
         state_next.sp_ctrl[BIT_IN_FULL] = 1'b1;
      if (sp_out_full_clr)
         state_next.sp_ctrl[BIT_OUT_FULL] = 1'b0;
      if (sp_out_full_set)
         state_next.sp_ctrl[BIT_OUT_FULL] = 1'b1;
      if (sp_in_ovf_set)
         state_next.sp_ctrl[BIT_IN_OVF] = 1'b1;
      state_next.sp_ctrl = state_next.sp_ctrl & SP_CTRL_MASK;

      if (bus_req.rd)
      begin
         case (bus_req.addr)
            ADDR_PIN_D:    state_next.rdata = pin_in_d;
            ADDR_PIN_E:    state_next.rdata = pin_in_e;
            ADDR_PIN_F:    state_next.rdata = pin_f_read;
            ADDR_LAT_D:    state_next.rdata = state_reg.lat_d;
            ADDR_LAT_E:    state_next.rdata = state_reg.lat_e;
            ADDR_LAT_F:    state_next.rdata = state_reg.lat_f;
            ADDR_DIR_D:    state_next.rdata = state_reg.dir_d;
            ADDR_DIR_E:    state_next.rdata = state_reg.dir_e;
            ADDR_DIR_F:    state_next.rdata = state_reg.dir_f;
            ADDR_SP_CTRL:  state_next.rdata = state_reg.sp_ctrl;
            ADDR_IRQ_STAT: state_next.rdata = state_reg.irq_stat;
            ADDR_IRQ_MASK: state_next.rdata = state_reg.irq_mask;
            ADDR_ANALOG_F: state_next.rdata = analog_f_sel;
            default:       state_next.rdata = 8'h00;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   // Latches get a defined zero here; software must not rely on it
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state_reg.lat_d    <= LAT_RESET;
         state_reg.lat_e    <= LAT_RESET;
         state_reg.lat_f    <= LAT_RESET;
         state_reg.dir_d    <= DIR_RESET;
         state_reg.dir_e    <= DIR_RESET;
         state_reg.dir_f    <= DIR_RESET;
         state_reg.sp_ctrl  <= CTRL_RESET;
         state_reg.irq_stat <= 8'h00;
         state_reg.irq_mask <= 8'h00;
         state_reg.rdata    <= 8'h00;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);

   dir_input_hiz_a: assert property (
      (state_reg.dir_f[0] && !$past(bus_req.wr)) |-> !pin_drv_f.pin_oe[0])
      else $error("input pin is driven");
   dir_output_drv_a: assert property (
      (!sp_mode && !state_reg.dir_d[3]) |->
       (pin_drv_d.pin_oe[3] && pin_drv_d.pin_out[3] == state_reg.lat_d[3]))
      else $error("output pin does not follow latch");
   lat_read_back_a: assert property (
      (bus_req.wr && bus_req.addr == ADDR_LAT_E) ##1
      (bus_req.rd && bus_req.addr == ADDR_LAT_E && !bus_req.wr) |=>
       bus_rdata == $past(bus_req.wdata, 2))
      else $error("latch read differs from write");
   pin_read_a: assert property (
      (bus_req.rd && hit(bus_req, ADDR_PIN_D)) |=>
       bus_rdata == $past(pin_in_d))
      else $error("pin read wrong");
   port_wr_lat_a: assert property (
      (bus_req.wr && bus_req.addr == ADDR_PIN_D) |=>
       state_reg.lat_d == $past(bus_req.wdata))
      else $error("port write missed latch");
   sp_drive_a: assert property (
      (sp_mode && pin_drv_d.pin_oe[0]) |->
       pin_drv_d.pin_out == sp_data_out)
      else $error("slave port data not on pins");
   sp_strobe_a: assert property (
      sp_mode |-> (sp_rd_strobe == !pin_in_e[PIN_RD_STB] &&
                   sp_wr_strobe == !pin_in_e[PIN_WR_STB]))
      else $error("slave strobe wrong");
   ctrl_low_zero_a: assert property (
      state_reg.sp_ctrl[3:0] == 4'h0)
      else $error("control low bits set");
   override_dir_a: assert property (
      (capcmp_en && !$past(bus_req.wr)) |->
       state_reg.dir_e == $past(state_reg.dir_e))
      else $error("override changed direction");

   // ----------------------------------------------------------------
   // Direction and drive
   // ----------------------------------------------------------------
   d_dir_oe_a: assert property (
      !sp_mode |-> pin_drv_d.pin_oe == ~state_reg.dir_d)
      else $error("port D enable differs from direction");
   e_dir_oe_a: assert property (
      (!sp_mode && !capcmp_en) |-> pin_drv_e.pin_oe == ~state_reg.dir_e)
      else $error("port E enable differs from direction");
   f_dir_oe_a: assert property (
      pin_drv_f.pin_oe == ~state_reg.dir_f)
      else $error("port F enable differs from direction");
   d_out_lat_a: assert property (
      !sp_mode |-> pin_drv_d.pin_out == state_reg.lat_d)
      else $error("port D drive differs from latch");
   e_out_lat_a: assert property (
      !capcmp_en |-> pin_drv_e.pin_out == state_reg.lat_e)
      else $error("port E drive differs from latch");
   f_out_lat_a: assert property (
      pin_drv_f.pin_out == state_reg.lat_f)
      else $error("port F drive differs from latch");

   // ----------------------------------------------------------------
   // Register access
   // ----------------------------------------------------------------
   lat_d_read_a: assert property (
      (bus_req.rd && hit(bus_req, ADDR_LAT_D)) |=>
       bus_rdata == $past(state_reg.lat_d))
      else $error("latch read returned other data");
   pin_e_read_a: assert property (
      (bus_req.rd && hit(bus_req, ADDR_PIN_E)) |=>
       bus_rdata == $past(pin_in_e))
      else $error("port E read is not the pin level");
   lat_e_write_a: assert property (
      (bus_req.wr && (hit(bus_req, ADDR_LAT_E) ||
                      hit(bus_req, ADDR_PIN_E))) |=>
       state_reg.lat_e == $past(bus_req.wdata))
      else $error("latch write lost");
   rdata_idle_a: assert property (
      !bus_req.rd |=> bus_rdata == 8'h00)
      else $error("read data stands too long");

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   dir_reset_a: assert property (
      !$past(rst_b) |-> (state_reg.dir_d == DIR_RESET &&
                         state_reg.dir_e == DIR_RESET &&
                         state_reg.dir_f == DIR_RESET))
      else $error("direction not all inputs after reset");
   lat_reset_a: assert property (
      !$past(rst_b) |-> (state_reg.lat_d == LAT_RESET &&
                         state_reg.lat_e == LAT_RESET &&
                         state_reg.lat_f == LAT_RESET))
      else $error("latch not cleared after reset");

   // ----------------------------------------------------------------
   // Slave port and shared pins
   // ----------------------------------------------------------------
   sp_read_drive_a: assert property (
      (sp_mode && !pin_in_e[PIN_RD_STB] && !pin_in_e[PIN_CSEL]) |->
       pin_drv_d.pin_oe == 8'hFF)
      else $error("slave read does not drive port D");
   sp_idle_hiz_a: assert property (
      (sp_mode && pin_in_e[PIN_RD_STB]) |->
       (pin_drv_d.pin_oe == 8'h00 && sp_data_in == pin_in_d))
      else $error("slave port drives D while idle");
   sp_e_input_a: assert property (
      sp_mode |-> (pin_drv_e.pin_oe & STROBES_E) == 8'h00)
      else $error("slave strobe pin driven");
   sp_wr_strobe_a: assert property (
      sp_wr_strobe == (sp_mode && !pin_in_e[PIN_WR_STB]))
      else $error("write strobe wrong");
   sp_csel_a: assert property (
      sp_chip_sel == (sp_mode && !pin_in_e[PIN_CSEL]))
      else $error("chip select wrong");
   capcmp_pin_a: assert property (
      capcmp_en |-> (pin_drv_e.pin_oe[PIN_CAPCMP] == capcmp_drive &&
                     pin_drv_e.pin_out[PIN_CAPCMP] == capcmp_out &&
                     capcmp_in == pin_in_e[PIN_CAPCMP]))
      else $error("shared pin E7 wrong");

   // ----------------------------------------------------------------
   // Flags, mode and analog read of port F
   // ----------------------------------------------------------------
   in_full_set_a: assert property (
      sp_in_full_set |=> state_reg.sp_ctrl[BIT_IN_FULL])
      else $error("input full flag not set");
   ovf_set_wins_a: assert property (
      sp_in_ovf_set |=> state_reg.sp_ctrl[BIT_IN_OVF])
      else $error("overflow flag lost to a clear");
   f_analog_zero_a: assert property (
      (bus_req.rd && hit(bus_req, ADDR_PIN_F) &&
       analog_f_sel == ANALOG_F_RESET) |=> bus_rdata[6:0] == 7'h00)
      else $error("analog port F pin read not zero");
   sp_mode_write_a: assert property (
      (bus_req.wr && hit(bus_req, ADDR_SP_CTRL)) |=>
       sp_mode == $past(bus_req.wdata[BIT_SP_EN]))
      else $error("slave mode bit not taken");
   out_empty_stat_a: assert property (
      sp_out_full_clr |=> state_reg.irq_stat[IRQ_OUT_EMPTY])
      else $error("output empty event lost");

   sp_mode_cov: cover property (sp_mode ##1 sp_rd_strobe);
   irq_cov: cover property (!irq ##1 irq);
   capcmp_cov: cover property (capcmp_en && capcmp_drive);
   sp_write_cov: cover property (sp_mode && sp_wr_strobe);
   wr_then_rd_cov: cover property (bus_req.wr ##1 bus_req.rd);

endmodule : gpio_ports_def

// >>> tb/pin_board.sv
// Board model for one 8-pin port: resolves each pin level.
// Assumes the board drives every pin that the device leaves released.
`timescale 1ns/1ps

module pin_board
   import gpio_def_pkg::*;
(
   input  wire pin_drv_s   drv,
   input  wire logic [7:0] ext,
   output logic      [7:0] level
);
   // Board drive reaches only pins the device has released, so a
   // fight on a driven pin can never hide a wrong enable
   assign level = (drv.pin_out & drv.pin_oe) | (ext & ~drv.pin_oe);
endmodule : pin_board

// >>> tb/tb_gpio_ports_d_e_f.sv
// Testbench for the D/E/F port block: register tasks plus pin model.
// Assumes the register map and field positions of gpio_def_pkg.
`timescale 1ns/1ps

module tb_gpio_ports_d_e_f
   import gpio_def_pkg::*;
;
   logic       sys_clk = 1'b0;
   logic       rst_b;
   reg_req_s   bus_req;
   logic [7:0] bus_rdata;
   logic [7:0] lvl_d, lvl_e, lvl_f, ext_d, ext_e, ext_f;
   pin_drv_s   drv_d, drv_e, drv_f;
   logic [7:0] sp_data_out, sp_data_in, analog_f_sel;
   logic       sp_rd_strobe, sp_wr_strobe, sp_chip_sel, irq;
   logic [4:0] evt;
   logic       capcmp_en, capcmp_drive, capcmp_out, capcmp_in;
   int         mismatches = 0;
   int         num_checks = 0;
   int         cycles = 0;

   always #25 sys_clk = ~sys_clk;

   gpio_ports_def DUT (.sys_clk(sys_clk), .rst_b(rst_b), .bus_req(bus_req),
      .bus_rdata(bus_rdata), .pin_in_d(lvl_d), .pin_drv_d(drv_d),
      .pin_in_e(lvl_e), .pin_drv_e(drv_e), .pin_in_f(lvl_f),
      .pin_drv_f(drv_f), .sp_data_out(sp_data_out),
      .sp_data_in(sp_data_in), .sp_rd_strobe(sp_rd_strobe),
      .sp_wr_strobe(sp_wr_strobe), .sp_chip_sel(sp_chip_sel),
      .sp_in_full_set(evt[0]), .sp_out_full_set(evt[1]),
      .sp_out_full_clr(evt[2]), .sp_in_ovf_set(evt[3]),
      .sp_in_full_clr(evt[4]), .capcmp_en(capcmp_en),
      .capcmp_drive(capcmp_drive), .capcmp_out(capcmp_out),
      .capcmp_in(capcmp_in), .analog_f_sel(analog_f_sel), .irq(irq));

   pin_board board_d (.drv(drv_d), .ext(ext_d), .level(lvl_d));
   pin_board board_e (.drv(drv_e), .ext(ext_e), .level(lvl_e));
   pin_board board_f (.drv(drv_f), .ext(ext_f), .level(lvl_f));

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task close_out;
      if (mismatches == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : close_out

   task check(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask : check

   task reg_wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge sys_clk);
      bus_req.wr <= 1'b0;
   endtask : reg_wr

   // Data stand only in the cycle after the strobe: sample mid-cycle
   task reg_rd(input logic [3:0] a, input logic [7:0] exp);
      @(posedge sys_clk);
      bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge sys_clk);
      bus_req.rd <= 1'b0;
      @(negedge sys_clk);
      check(bus_rdata, exp);
   endtask : reg_rd

   task pulse(input int i);
      @(posedge sys_clk);
      evt[i] <= 1'b1;
      @(posedge sys_clk);
      evt[i] <= 1'b0;
   endtask : pulse

   task reset_checks;
      for (int p = 0; p < 3; p++)
         reg_rd(4'(3 * p + 2), DIR_RESET);
      check(drv_d.pin_oe | drv_e.pin_oe | drv_f.pin_oe, 8'h00);
      reg_rd(ADDR_SP_CTRL, 8'h00);
      check(irq, 1'b0);
   endtask : reset_checks

   function automatic logic [7:0] ext_of(input int p);
      return (p == 0) ? ext_d : (p == 1) ? ext_e : ext_f;
   endfunction : ext_of

   function automatic pin_drv_s drv_of(input int p);
      return (p == 0) ? drv_d : (p == 1) ? drv_e : drv_f;
   endfunction : drv_of

   // ----------------------------------------------------------------
   // Sequence
   // ----------------------------------------------------------------
   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 2000)
      begin
         mismatches++;
         close_out();
      end
   end

   initial
   begin
      rst_b = 1'b0;
      bus_req = '0;
      ext_d = 8'h3C;
      ext_e = 8'hFF;
      ext_f = 8'hFF;
      sp_data_out = 8'hA5;
      evt = '0;
      capcmp_en = 1'b0;
      capcmp_drive = 1'b0;
      capcmp_out = 1'b0;
      analog_f_sel = ANALOG_F_RESET;
      repeat (5) @(posedge sys_clk);
      rst_b <= 1'b1;
      reset_checks();
      reg_rd(ADDR_PIN_F, 8'h80);
      @(posedge sys_clk);
      analog_f_sel <= 8'h00;
      // Same latch through both addresses; pins read back, not latch
      for (int p = 0; p < 3; p++)
      begin
         reg_wr(4'(3 * p), 8'h5A);
         reg_rd(4'(3 * p + 1), 8'h5A);
         reg_wr(4'(3 * p + 1), 8'hC3);
         reg_wr(4'(3 * p + 2), 8'hF0);
         @(negedge sys_clk);
         check(drv_of(p).pin_oe, 8'h0F);
         check(drv_of(p).pin_out & 8'h0F, 8'h03);
         reg_rd(4'(3 * p), 8'h03 | (ext_of(p) & 8'hF0));
         reg_rd(4'(3 * p + 1), 8'hC3);
      end
      // Write then read the E latch with no gap between the strobes
      @(posedge sys_clk);
      bus_req <= '{addr: ADDR_LAT_E, wdata: 8'h96, wr: 1'b1, rd: 1'b0};
      @(posedge sys_clk);
      bus_req <= '{addr: ADDR_LAT_E, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge sys_clk);
      bus_req.rd <= 1'b0;
      @(negedge sys_clk);
      check(bus_rdata, 8'h96);
      // Slave mode: E0 low, E1 high, E2 low means read with select
      reg_wr(ADDR_DIR_E, 8'h00);
      ext_e <= 8'hFA;
      reg_wr(ADDR_SP_CTRL, 8'hFF);
      reg_rd(ADDR_SP_CTRL, 8'h10);
      check(drv_e.pin_oe & STROBES_E, 8'h00);
      check({sp_chip_sel, sp_wr_strobe, sp_rd_strobe}, 3'b101);
      check(drv_d.pin_oe, 8'hFF);
      check(drv_d.pin_out, 8'hA5);
      reg_rd(ADDR_DIR_E, 8'h00);
      @(posedge sys_clk);
      ext_e <= 8'hFD;
      @(negedge sys_clk);
      check({sp_chip_sel, sp_wr_strobe, sp_rd_strobe}, 3'b010);
      check(drv_d.pin_oe, 8'h00);
      check(sp_data_in, ext_d);
      // Flags come from hardware only; events latch into status
      pulse(0);
      pulse(3);
      reg_rd(ADDR_SP_CTRL, 8'hB0);
      reg_rd(ADDR_IRQ_STAT, 8'h05);
      check(irq, 1'b0);
      reg_wr(ADDR_IRQ_MASK, 8'h07);
      @(negedge sys_clk);
      check(irq, 1'b1);
      pulse(4);
      pulse(1);
      reg_rd(ADDR_SP_CTRL, 8'h70);
      pulse(2);
      reg_rd(ADDR_SP_CTRL, 8'h30);
      reg_rd(ADDR_IRQ_STAT, IRQ_IMPL);
      reg_wr(ADDR_IRQ_STAT, IRQ_IMPL);
      reg_rd(ADDR_IRQ_STAT, 8'h00);
      check(irq, 1'b0);
      reg_wr(ADDR_SP_CTRL, 8'h00);
      // E7 taken by compare output though its direction says input
      reg_wr(ADDR_DIR_E, 8'h80);
      capcmp_en <= 1'b1;
      capcmp_drive <= 1'b1;
      @(negedge sys_clk);
      check({drv_e.pin_oe[7], drv_e.pin_out[7]}, 2'b10);
      check(capcmp_in, 1'b0);
      reg_rd(ADDR_DIR_E, 8'h80);
      @(posedge sys_clk);
      capcmp_drive <= 1'b0;
      @(negedge sys_clk);
      check({drv_e.pin_oe[7], capcmp_in}, 2'b01);
      @(posedge sys_clk);
      capcmp_en <= 1'b0;
      reg_wr(4'hD, 8'hFF);
      reg_rd(4'hD, 8'h00);
      reg_rd(ADDR_ANALOG_F, 8'h00);
      @(negedge sys_clk);
      check(bus_rdata, 8'h00);
      // Reset in mid-run restores every direction to input
      @(posedge sys_clk);
      rst_b <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rst_b <= 1'b1;
      reset_checks();
      close_out();
   end
endmodule : tb_gpio_ports_d_e_f
